//--- ascii_poll_pkg.sv
// Constants and types shared by the framed ASCII command parser.
// Assumes byte-wide serial data and a 32-bit Avalon-MM register port.
package ascii_poll_pkg;

  // Framing and command characters
  localparam logic [7:0] CH_STX   = 8'h02;
  localparam logic [7:0] CH_ETX   = 8'h03;
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_PLUS  = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_NINE  = 8'h39;
  localparam logic [7:0] CH_A     = 8'h41;
  localparam logic [7:0] CH_D     = 8'h44;
  localparam logic [7:0] CH_K     = 8'h4B;
  localparam logic [7:0] CH_M     = 8'h4D;
  localparam logic [7:0] CH_N     = 8'h4E;
  localparam logic [7:0] CH_S     = 8'h53;
  localparam logic [7:0] CH_T     = 8'h54;

  localparam logic [7:0] CHK_SEED = 8'h00;

  // Address field and reply layout
  localparam logic [1:0] ADDR_CHARS    = 2'd3;
  localparam logic [4:0] HDR_LAST_POS  = 5'd4;
  localparam logic [4:0] REC_ADDR_POS  = 5'd1;
  localparam logic [4:0] REC_SP1_POS   = 5'd4;
  localparam logic [4:0] REC_MANT_POS  = 5'd5;
  localparam logic [4:0] REC_EXP_POS   = 5'd10;
  localparam logic [4:0] REC_SP2_POS   = 5'd13;
  localparam logic [4:0] REC_OP_POS    = 5'd14;
  localparam logic [4:0] REC_SP3_POS   = 5'd16;
  localparam logic [4:0] REC_ERR_POS   = 5'd17;
  localparam logic [4:0] REC_SP4_POS   = 5'd19;
  localparam logic [4:0] REC_RSVD_POS  = 5'd20;
  localparam logic [4:0] REC_LAST_POS  = 5'd29;
  localparam logic [2:0] LAST_REC_SINGLE = 3'd3;
  localparam logic [2:0] LAST_REC_DUAL   = 3'd7;

  // Operating status bit positions
  localparam int OPS_SERVICE = 0;
  localparam int OPS_LOCAL   = 1;
  localparam int OPS_ZERO    = 2;
  localparam int OPS_SPAN    = 3;
  localparam int OPS_UNIT    = 4;
  localparam int OPS_OZON    = 5;
  localparam int OPS_PMT     = 6;

  // Register map (byte addresses)
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_POLLS  = 4'h8;
  localparam int CFG_ADDR_LSB = 0;
  localparam int CFG_ZS_BIT   = 8;
  localparam int STS_GAS_LSB  = 0;
  localparam int STS_BUSY_BIT = 2;
  localparam logic [6:0] CFG_ADDR_RST = 7'h00;
  localparam logic       CFG_ZS_RST   = 1'b0;

  typedef enum logic [1:0] {GAS_SAMPLE, GAS_ZERO, GAS_SPAN} gas_mode_t;
  typedef enum logic [2:0] {
    RX_IDLE, RX_CMD2, RX_BODY, RX_TERM, RX_CHK_HI, RX_CHK_LO
  } rx_state_t;
  typedef enum logic [2:0] {
    TX_IDLE, TX_HDR, TX_REC, TX_END, TX_CHK_HI, TX_CHK_LO
  } tx_state_t;

endpackage

//--- hex_char_codec.sv
// Converts a nibble to an upper-case hex character and back.
// Purely combinational; used for checksums and status bytes.
`timescale 1ns/100ps
module hex_char_codec (
  input  wire logic [3:0] nibble_i,
  input  wire logic [7:0] char_i,
  output logic      [7:0] char_o,
  output logic      [3:0] nibble_o,
  output logic            is_hex_o
);
  always_comb begin
    char_o = (nibble_i < 4'hA) ? {4'h3, nibble_i}
                               : 8'(8'h37 + {4'h0, nibble_i});
    nibble_o = 4'h0;
    is_hex_o = 1'b1;
    if (char_i >= 8'h30 && char_i <= 8'h39) begin
      nibble_o = char_i[3:0];
    end else if ((char_i >= 8'h41 && char_i <= 8'h46) ||
                 (char_i >= 8'h61 && char_i <= 8'h66)) begin
      nibble_o = 4'(char_i[3:0] + 4'h9);
    end else begin
      is_hex_o = 1'b0;
    end
  end
endmodule

//--- addr_decimal.sv
// Turns a record address (0..255) into three zero-padded decimal digits.
// Purely combinational.
`timescale 1ns/100ps
module addr_decimal (
  input  wire logic [7:0] value_i,
  output logic      [7:0] hund_o,
  output logic      [7:0] tens_o,
  output logic      [7:0] ones_o
);
  logic [7:0] rem;
  always_comb begin
    hund_o = {4'h3, 4'(value_i / 8'd100)};
    rem    = 8'(value_i % 8'd100);
    tens_o = {4'h3, 4'(rem / 8'd10)};
    ones_o = {4'h3, 4'(rem % 8'd10)};
  end
endmodule

//--- ascii_poll_command_parser.sv
// Framed ASCII command parser: gas-mode switch and measurement poll.
// Assumes rx bytes arrive as one-cycle strobes and tx uses valid/ready.
//
// What this block does
// - Frame starts with STX and ends with ETX or CR.
// - ETX is followed by two checksum chars; CR by none.
// - Checksum is XOR from zero over all chars incl. STX and ETX.
// - Checksum travels as two hex chars, high nibble first.
// - Gas-mode switch acts only outside service mode with option fitted.
// - Letter N selects zero, K span, M sample.
// - Switch command: S T, optional address, optional space, letter.
// - Malformed frames or foreign addresses are dropped silently.
// - Address is optional; if present must match; spaces may follow.
// - Poll without address allows no spaces at all.
// - Poll answered only when framing, address and checksum hold.
// - Reply uses same terminator; ETX form carries fresh checksum.
// - Reply opens STX M D, two-digit record count, space.
// - Records: address, value, status, reserved; address steps by one.
// - Value: signed four-digit mantissa, signed two-digit exponent.
// - Status: operating byte, space, error byte, each two hex chars.
// - Reserved field is ten ASCII zeros.
// - Invalid measurement still sends its record with value zero.
// - Values go out in the instrument's currently selected units.
// - STX 0x02, ETX 0x03, CR 0x0D, separator is space.
// - Address 0 to 127, three chars, zero or space padded.
// - Operating status flags occupy bits 0 to 6 as listed.
// - Four records in single range, eight in dual/auto range.
//
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
module ascii_poll_command_parser (
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  input  wire logic [3:0]              avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [31:0]             avs_writedata_i,
  output logic      [31:0]             avs_readdata_o,
  output logic                         avs_waitrequest_o,
  input  wire logic [7:0]              rx_data_i,
  input  wire logic                    rx_valid_i,
  output logic      [7:0]              tx_data_o,
  output logic                         tx_valid_o,
  input  wire logic                    tx_ready_i,
  input  wire logic                    service_mode_i,
  input  wire logic                    local_maint_i,
  input  wire logic                    gas_unit_i,
  input  wire logic                    ozonator_off_i,
  input  wire logic                    pmt_off_i,
  input  wire logic                    range_dual_i,
  input  wire logic [7:0]              err_status_i,
  input  wire logic [7:0]              meas_valid_i,
  input  wire logic [7:0]              meas_mant_neg_i,
  input  wire logic [7:0][15:0]        meas_mant_bcd_i,
  input  wire logic [7:0]              meas_exp_neg_i,
  input  wire logic [7:0][7:0]         meas_exp_bcd_i,
  output ascii_poll_pkg::gas_mode_t    gas_mode_o
);
  import ascii_poll_pkg::*;

  typedef struct packed {
    rx_state_t  rx;
    logic       is_poll;
    logic [1:0] addr_cnt;
    logic       addr_digit;
    logic [9:0] addr_val;
    gas_mode_t  pend;
    logic [7:0] rx_chk;
    logic [3:0] chk_hi;
    tx_state_t  tx;
    logic [4:0] pos;
    logic [2:0] rec;
    logic [2:0] last_rec;
    logic       tx_etx;
    logic [7:0] tx_chk;
    logic [7:0] tx_data;
    logic       tx_valid;
    gas_mode_t  gas;
    logic [6:0] cfg_addr;
    logic       cfg_zs;
    logic [15:0] polls;
    logic       waitreq;
    logic [31:0] rdata;
  } state_t;

  localparam state_t STATE_RST = '{
    rx: RX_IDLE, is_poll: 1'b0, addr_cnt: 2'd0, addr_digit: 1'b0,
    addr_val: 10'h000, pend: GAS_SAMPLE, rx_chk: CHK_SEED, chk_hi: 4'h0,
    tx: TX_IDLE, pos: 5'd0, rec: 3'd0, last_rec: 3'd0, tx_etx: 1'b0,
    tx_chk: CHK_SEED, tx_data: 8'h00, tx_valid: 1'b0, gas: GAS_SAMPLE,
    cfg_addr: CFG_ADDR_RST, cfg_zs: CFG_ZS_RST, polls: 16'h0000,
    waitreq: 1'b1, rdata: 32'h0000_0000
  };

  state_t s_q;
  state_t s_d;

  logic [7:0] b;
  logic       is_digit;
  logic [3:0] rx_nib;
  logic       rx_is_hex;
  logic       shape_ok;
  logic       addr_match;
  logic       frame_done;
  logic       frame_etx;
  logic [3:0] tx_nib;
  logic [7:0] tx_hex;
  logic [7:0] addr_h;
  logic [7:0] addr_t;
  logic [7:0] addr_o;
  logic [7:0] cur_byte;
  logic [7:0] op_status;
  logic [4:0] off;
  logic       meas_ok;
  logic [15:0] mant;
  logic [7:0]  expo;
  logic        advance;

  hex_char_codec rx_codec (
    .nibble_i (4'h0),
    .char_i   (rx_data_i),
    .char_o   (),
    .nibble_o (rx_nib),
    .is_hex_o (rx_is_hex)
  );

  hex_char_codec tx_codec (
    .nibble_i (tx_nib),
    .char_i   (8'h00),
    .char_o   (tx_hex),
    .nibble_o (),
    .is_hex_o ()
  );

  addr_decimal rec_addr (
    .value_i (8'({1'b0, s_q.cfg_addr} + {5'h00, s_q.rec})),
    .hund_o  (addr_h),
    .tens_o  (addr_t),
    .ones_o  (addr_o)
  );

  // Reply byte for the current transmit position
  always_comb begin
    op_status = 8'h00;
    op_status[OPS_SERVICE] = service_mode_i;
    op_status[OPS_LOCAL]   = local_maint_i;
    op_status[OPS_ZERO]    = (s_q.gas == GAS_ZERO);
    op_status[OPS_SPAN]    = (s_q.gas == GAS_SPAN);
    op_status[OPS_UNIT]    = gas_unit_i;
    op_status[OPS_OZON]    = ozonator_off_i;
    op_status[OPS_PMT]     = pmt_off_i;
    meas_ok  = meas_valid_i[s_q.rec];
    mant     = meas_ok ? meas_mant_bcd_i[s_q.rec] : 16'h0000;
    expo     = meas_ok ? meas_exp_bcd_i[s_q.rec] : 8'h00;
    off      = 5'd0;
    tx_nib   = 4'h0;
    cur_byte = CH_SP;
    unique case (s_q.tx)
      TX_HDR: begin
        unique case (s_q.pos)
          5'd0:    cur_byte = CH_STX;
          5'd1:    cur_byte = CH_M;
          5'd2:    cur_byte = CH_D;
          5'd3:    cur_byte = CH_ZERO;
          default: cur_byte = 8'(CH_ZERO + {5'h00, s_q.last_rec} + 8'h01);
        endcase
      end
      TX_REC: begin
        if (s_q.pos >= REC_RSVD_POS) begin
          cur_byte = CH_ZERO;
        end else if (s_q.pos >= REC_ERR_POS && s_q.pos < REC_SP4_POS) begin
          tx_nib   = (s_q.pos == REC_ERR_POS) ? err_status_i[7:4]
                                              : err_status_i[3:0];
          cur_byte = tx_hex;
        end else if (s_q.pos >= REC_OP_POS && s_q.pos < REC_SP3_POS) begin
          tx_nib   = (s_q.pos == REC_OP_POS) ? op_status[7:4]
                                             : op_status[3:0];
          cur_byte = tx_hex;
        end else if (s_q.pos == REC_EXP_POS) begin
          cur_byte = (meas_ok && meas_exp_neg_i[s_q.rec]) ? CH_MINUS
                                                          : CH_PLUS;
        end else if (s_q.pos > REC_EXP_POS && s_q.pos < REC_SP2_POS) begin
          off      = 5'(s_q.pos - REC_EXP_POS - 5'd1);
          cur_byte = {4'h3, (off == 5'd0) ? expo[7:4] : expo[3:0]};
        end else if (s_q.pos == REC_MANT_POS) begin
          cur_byte = (meas_ok && meas_mant_neg_i[s_q.rec]) ? CH_MINUS
                                                           : CH_PLUS;
        end else if (s_q.pos > REC_MANT_POS && s_q.pos < REC_EXP_POS) begin
          off      = 5'(s_q.pos - REC_MANT_POS - 5'd1);
          cur_byte = {4'h3, mant[4'(4'd15 - {off[1:0], 2'b00}) -: 4]};
        end else if (s_q.pos >= REC_ADDR_POS && s_q.pos < REC_SP1_POS) begin
          cur_byte = (s_q.pos == REC_ADDR_POS) ? addr_h :
                     (s_q.pos == 5'd2)          ? addr_t : addr_o;
        end else begin
          cur_byte = CH_SP;
        end
      end
      TX_END:    cur_byte = s_q.tx_etx ? CH_ETX : CH_CR;
      TX_CHK_HI: begin
        tx_nib   = s_q.tx_chk[7:4];
        cur_byte = tx_hex;
      end
      TX_CHK_LO: begin
        tx_nib   = s_q.tx_chk[3:0];
        cur_byte = tx_hex;
      end
      TX_IDLE:   cur_byte = CH_SP;
    endcase
  end

  always_comb begin
    s_d        = s_q;
    b          = rx_data_i;
    is_digit   = (b >= CH_ZERO) && (b <= CH_NINE);
    frame_done = 1'b0;
    frame_etx  = 1'b0;
    addr_match = !s_q.addr_digit ||
                 (s_q.addr_val == {3'b000, s_q.cfg_addr});
    // Bare spaces act as separator only for the switch command
    shape_ok   = (s_q.addr_cnt == 2'd0) ||
                 (s_q.addr_cnt == ADDR_CHARS && s_q.addr_digit) ||
                 (!s_q.addr_digit && !s_q.is_poll);

    // Receive side
    if (rx_valid_i) begin
      if (s_q.rx != RX_CHK_HI && s_q.rx != RX_CHK_LO) begin
        s_d.rx_chk = s_q.rx_chk ^ b;
      end
      if (b == CH_STX) begin
        s_d.rx         = RX_CMD2;
        s_d.rx_chk     = CHK_SEED ^ CH_STX;
        s_d.addr_cnt   = 2'd0;
        s_d.addr_digit = 1'b0;
        s_d.addr_val   = 10'h000;
        s_d.is_poll    = 1'b0;
      end else begin
        unique case (s_q.rx)
          RX_IDLE: s_d.rx = RX_IDLE;
          RX_CMD2: begin
            // Second letter only after a valid first letter
            if (s_q.addr_cnt != 2'd0 &&
                (s_q.is_poll ? (b == CH_A) : (b == CH_T))) begin
              s_d.rx = RX_BODY;
            end else if (!s_q.is_poll && s_q.addr_cnt == 2'd0 &&
                         (b == CH_S || b == CH_D)) begin
              s_d.is_poll  = (b == CH_D);
              s_d.addr_cnt = 2'd1;
            end else begin
              s_d.rx = RX_IDLE;
            end
            if (b == CH_T || b == CH_A) begin
              s_d.addr_cnt = 2'd0;
            end
          end
          RX_BODY: begin
            if (is_digit && s_q.addr_cnt != ADDR_CHARS) begin
              s_d.addr_val   = 10'(s_q.addr_val * 10'd10 + {6'h00, b[3:0]});
              s_d.addr_digit = 1'b1;
              s_d.addr_cnt   = 2'(s_q.addr_cnt + 2'd1);
            end else if (b == CH_SP) begin
              if (s_q.addr_cnt != ADDR_CHARS) begin
                s_d.addr_cnt = 2'(s_q.addr_cnt + 2'd1);
                if (s_q.addr_digit) begin
                  s_d.rx = RX_IDLE;
                end
              end
            end else if (!shape_ok || !addr_match) begin
              s_d.rx = RX_IDLE;
            end else if (s_q.is_poll) begin
              frame_done = (b == CH_CR);
              s_d.rx     = (b == CH_ETX) ? RX_CHK_HI : RX_IDLE;
            end else if (b == CH_N || b == CH_K || b == CH_M) begin
              s_d.pend = (b == CH_N) ? GAS_ZERO :
                         (b == CH_K) ? GAS_SPAN : GAS_SAMPLE;
              s_d.rx   = RX_TERM;
            end else begin
              s_d.rx = RX_IDLE;
            end
          end
          RX_TERM: begin
            frame_done = (b == CH_CR);
            s_d.rx     = (b == CH_ETX) ? RX_CHK_HI : RX_IDLE;
          end
          RX_CHK_HI: begin
            s_d.chk_hi = rx_nib;
            s_d.rx     = rx_is_hex ? RX_CHK_LO : RX_IDLE;
          end
          RX_CHK_LO: begin
            frame_done = rx_is_hex && ({s_q.chk_hi, rx_nib} == s_q.rx_chk);
            frame_etx  = 1'b1;
            s_d.rx     = RX_IDLE;
          end
        endcase
      end
    end

    if (frame_done) begin
      if (!s_q.is_poll) begin
        if (!service_mode_i && s_q.cfg_zs) begin
          s_d.gas = s_q.pend;
        end
      end else if (s_q.tx == TX_IDLE) begin
        s_d.tx       = TX_HDR;
        s_d.pos      = 5'd0;
        s_d.rec      = 3'd0;
        s_d.tx_etx   = frame_etx;
        s_d.tx_chk   = CHK_SEED;
        s_d.last_rec = range_dual_i ? LAST_REC_DUAL
                                    : LAST_REC_SINGLE;
        s_d.polls    = 16'(s_q.polls + 16'h0001);
      end
    end

    // Transmit side
    advance = !s_q.tx_valid || tx_ready_i;
    if (advance) begin
      s_d.tx_valid = (s_q.tx != TX_IDLE);
      if (s_q.tx != TX_IDLE) begin
        s_d.tx_data = cur_byte;
      end
      if (s_q.tx == TX_HDR || s_q.tx == TX_REC || s_q.tx == TX_END) begin
        s_d.tx_chk = s_q.tx_chk ^ cur_byte;
      end
      unique case (s_q.tx)
        // Keeps a reply start requested by the receive side
        TX_IDLE: begin
        end
        TX_HDR: begin
          s_d.pos = 5'(s_q.pos + 5'd1);
          if (s_q.pos == HDR_LAST_POS) begin
            s_d.tx  = TX_REC;
            s_d.pos = 5'd0;
          end
        end
        TX_REC: begin
          s_d.pos = 5'(s_q.pos + 5'd1);
          if (s_q.pos == REC_LAST_POS) begin
            s_d.pos = 5'd0;
            s_d.rec = 3'(s_q.rec + 3'd1);
            if (s_q.rec == s_q.last_rec) begin
              s_d.tx = TX_END;
            end
          end
        end
        TX_END:    s_d.tx = s_q.tx_etx ? TX_CHK_HI : TX_IDLE;
        TX_CHK_HI: s_d.tx = TX_CHK_LO;
        TX_CHK_LO: s_d.tx = TX_IDLE;
      endcase
    end

    // Avalon-MM slave: one wait state per access
    s_d.waitreq = !((avs_read_i || avs_write_i) && s_q.waitreq);
    if (avs_read_i && s_q.waitreq) begin
      s_d.rdata = 32'h0000_0000;
      unique case (avs_address_i)
        REG_CONFIG: begin
          s_d.rdata[CFG_ADDR_LSB +: 7] = s_q.cfg_addr;
          s_d.rdata[CFG_ZS_BIT]        = s_q.cfg_zs;
        end
        REG_STATUS: begin
          s_d.rdata[STS_GAS_LSB +: 2] = s_q.gas;
          s_d.rdata[STS_BUSY_BIT]     = (s_q.tx != TX_IDLE);
        end
        REG_POLLS: s_d.rdata[15:0] = s_q.polls;
        default:   s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write_i && !s_q.waitreq && avs_address_i == REG_CONFIG) begin
      s_d.cfg_addr = avs_writedata_i[CFG_ADDR_LSB +: 7];
      s_d.cfg_zs   = avs_writedata_i[CFG_ZS_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata_o    = s_q.rdata;
  assign avs_waitrequest_o = s_q.waitreq;
  assign tx_data_o         = s_q.tx_data;
  assign tx_valid_o        = s_q.tx_valid;
  assign gas_mode_o        = s_q.gas;

endmodule

//--- ascii_host_model.sv
// Remote host model: sends framed commands, collects reply bytes.
// Assumes the parser clock; ready toggles while stall_i is high.
`timescale 1ns/100ps
module ascii_host_model (
  input  wire logic       clk_i,
  input  wire logic       stall_i,
  input  wire logic [7:0] tx_data_o,
  input  wire logic       tx_valid_o,
  output logic      [7:0] rx_data_i,
  output logic            rx_valid_i,
  output logic            tx_ready_i
);
  logic [7:0] got[$];
  logic       tog = 1'b0;
  initial begin
    rx_data_i  = 8'hA5;
    rx_valid_i = 1'b0;
  end
  assign tx_ready_i = ~stall_i | tog;
  always @(posedge clk_i) begin
    tog <= ~tog;
    if (tx_valid_o && tx_ready_i)
      got.push_back(tx_data_o);
  end
  function automatic logic [7:0] hx(input logic [3:0] v);
    return v < 4'hA ? 8'h30 + v : 8'h37 + v;
  endfunction
  // Bad flips the checksum low bit
  task automatic send(input logic [7:0] b[$], input bit etx, bad);
    logic [7:0] f[$];
    logic [7:0] x;
    f = {8'h02, b, etx ? 8'h03 : 8'h0D};
    x = {7'h00, bad};
    foreach (f[i]) x ^= f[i];
    if (etx)
      f = {f, hx(x[7:4]), hx(x[3:0])};
    foreach (f[i]) begin
      @(posedge clk_i);
      rx_data_i  <= f[i];
      rx_valid_i <= 1'b1;
    end
    @(posedge clk_i);
    rx_valid_i <= 1'b0;
    rx_data_i  <= ~f[f.size()-1];
  endtask
endmodule

//--- ascii_poll_sva.sv
// Port checker for the ASCII command parser.
// Assumes one clock and an async active-high reset.
`timescale 1ns/100ps
module ascii_poll_sva (
  input wire logic                      clk_i,
  input wire logic                      sys_rst_i,
  input wire logic                      avs_read_i,
  input wire logic                      avs_write_i,
  input wire logic                      avs_waitrequest_o,
  input wire logic                      rx_valid_i,
  input wire logic [7:0]                tx_data_o,
  input wire logic                      tx_valid_o,
  input wire logic                      tx_ready_i,
  input wire logic                      service_mode_i,
  input wire ascii_poll_pkg::gas_mode_t gas_mode_o
);
  import ascii_poll_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  chk_bus_answer: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no bus answer");
  chk_tx_hold: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_data_o)) else $error("byte lost in stall");
  chk_tx_release: assert property ($fell(tx_valid_o) |-> $past(tx_ready_i))
    else $error("valid fell without ready");
  chk_reply_start: assert property (
    $rose(tx_valid_o) |-> tx_data_o == CH_STX) else $error("no start char");
  chk_reply_cause: assert property (
    $rose(tx_valid_o) |-> $past(rx_valid_i, 2)) else $error("reply uncaused");
  chk_gas_byte: assert property (
    !$stable(gas_mode_o) |-> $past(rx_valid_i)) else $error("gas uncaused");
  chk_gas_service: assert property (
    !$stable(gas_mode_o) |-> !$past(service_mode_i))
    else $error("gas moved in service");
  chk_reset_idle: assert property ($fell(sys_rst_i) |-> avs_waitrequest_o &&
    !tx_valid_o && gas_mode_o == GAS_SAMPLE) else $error("bad reset state");
  cov_read: cover property (avs_read_i && !avs_waitrequest_o);
  cov_stall: cover property (tx_valid_o && !tx_ready_i);
  cov_gas: cover property (!$stable(gas_mode_o));
endmodule
bind ascii_poll_command_parser ascii_poll_sva i_sva (
  .clk_i, .sys_rst_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o,
  .rx_valid_i, .tx_data_o, .tx_valid_o, .tx_ready_i, .service_mode_i,
  .gas_mode_o
);

//--- ascii_poll_command_parser_bench.sv
// Testbench: registers, gas-mode switches and polls with replies.
// Assumes host model and checker are compiled before this file.
`timescale 1ns/100ps
module ascii_poll_command_parser_bench;
  import ascii_poll_pkg::*;
  logic             clk_i = 1'b0, sys_rst_i = 1'b1, stall = 1'b0;
  logic [3:0]       avs_address_i = 4'h0;
  logic             avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [31:0]      avs_writedata_i = 32'h0, avs_readdata_o, rd;
  logic             avs_waitrequest_o, rx_valid_i, tx_valid_o, tx_ready_i;
  logic [7:0]       rx_data_i, tx_data_o;
  logic             service_mode_i = 1'b0, range_dual_i = 1'b0;
  logic             ozonator_off_i = 1'b0, pmt_off_i = 1'b0;
  logic             local_maint_i = 1'b1, gas_unit_i = 1'b1;
  logic [7:0]       err_status_i = 8'h3C, meas_valid_i = 8'hFD;
  logic [7:0]       meas_mant_neg_i = 8'h24, meas_exp_neg_i = 8'h48;
  logic [7:0][15:0] meas_mant_bcd_i = {8{16'h5681}};
  logic [7:0][7:0]  meas_exp_bcd_i = {8{8'h01}};
  gas_mode_t        gas_mode_o, gm = GAS_SAMPLE;
  int               error_cnt = 0, total_checks = 0;
  logic [7:0]       e[$];
  ascii_poll_command_parser i_dut (
    .clk_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .rx_data_i,
    .rx_valid_i, .tx_data_o, .tx_valid_o, .tx_ready_i, .service_mode_i,
    .local_maint_i, .gas_unit_i, .ozonator_off_i, .pmt_off_i, .range_dual_i,
    .err_status_i, .meas_valid_i, .meas_mant_neg_i, .meas_mant_bcd_i,
    .meas_exp_neg_i, .meas_exp_bcd_i, .gas_mode_o
  );
  ascii_host_model i_host (
    .clk_i, .stall_i(stall), .tx_data_o, .tx_valid_o, .rx_data_i,
    .rx_valid_i, .tx_ready_i
  );
  initial forever #2.5 clk_i = ~clk_i;
  initial begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
  end
  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end
  task automatic chk(input string n, input logic [31:0] s, x);
    total_checks++;
    if (s !== x) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (n >= 50)
      error_cnt++;
  endtask
  function automatic logic [7:0] hx(input logic [7:0] v);
    return v < 8'hA ? 8'h30 + v : 8'h37 + v;
  endfunction
  task automatic build(input bit etx);
    logic [7:0]  a, x, op, ex;
    logic [15:0] m;
    logic        w;
    int          nr;
    nr = range_dual_i ? 8 : 4;
    op = {1'b0, pmt_off_i, ozonator_off_i, gas_unit_i, gm == GAS_SPAN,
          gm == GAS_ZERO, local_maint_i, service_mode_i};
    e = {CH_STX, CH_M, CH_D, CH_ZERO, CH_ZERO + nr[7:0]};
    for (int r = 0; r < nr; r++) begin
      w = meas_valid_i[r];
      a = 8'h05 + r[7:0];
      m = w ? meas_mant_bcd_i[r] : 16'h0;
      ex = w ? meas_exp_bcd_i[r] : 8'h0;
      e = {e, CH_SP, hx(a / 100), hx(a / 10 % 10), hx(a % 10), CH_SP,
           w & meas_mant_neg_i[r] ? CH_MINUS : CH_PLUS, hx(m[15:12]),
           hx(m[11:8]), hx(m[7:4]), hx(m[3:0]),
           w & meas_exp_neg_i[r] ? CH_MINUS : CH_PLUS, hx(ex[7:4]),
           hx(ex[3:0]), CH_SP, hx(op[7:4]), hx(op[3:0]), CH_SP,
           hx(err_status_i[7:4]), hx(err_status_i[3:0]), CH_SP};
      repeat (10) e.push_back(CH_ZERO);
    end
    if (etx) begin
      e.push_back(CH_ETX);
      x = 8'h00;
      foreach (e[i]) x ^= e[i];
      e = {e, hx(x[7:4]), hx(x[3:0])};
    end else
      e.push_back(CH_CR);
  endtask
  task automatic poll(input logic [7:0] b[$], input bit etx, bad, ok);
    int n;
    n = 0;
    i_host.send(b, etx, bad);
    e.delete();
    if (ok)
      build(etx);
    while (i_host.got.size() < e.size() && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    repeat (40) @(posedge clk_i);
    chk("reply_len", i_host.got.size(), e.size());
    foreach (e[i])
      if (i < i_host.got.size())
        chk("reply_byte", i_host.got[i], e[i]);
    i_host.got.delete();
    $display("poll test done");
  endtask
  task automatic switch_gas(input logic [7:0] c, input gas_mode_t g,
                            input bit ad);
    if (ad)
      i_host.send({CH_S, CH_T, CH_ZERO, CH_ZERO, 8'h35, CH_SP, c}, 1'b1, 1'b0);
    else
      i_host.send({CH_S, CH_T, c}, 1'b0, 1'b0);
    repeat (2) @(posedge clk_i);
    gm = g;
    chk("gas_mode", gas_mode_o, gm);
    $display("switch test done");
  endtask
  initial begin
    @(negedge sys_rst_i);
    for (int a = 0; a < 16; a += 4) begin
      bus(1'b0, a[3:0], 32'h0);
      chk("reg_reset", rd, 32'h0);
    end
    bus(1'b1, REG_CONFIG, 32'h0000_0105);
    bus(1'b1, REG_STATUS, 32'hFFFF_FFFF);
    bus(1'b0, REG_CONFIG, 32'h0);
    chk("config", rd, 32'h0000_0105);
    $display("register test done");
    switch_gas(CH_K, GAS_SPAN, 1'b1);
    switch_gas(CH_M, GAS_SAMPLE, 1'b0);
    switch_gas(CH_N, GAS_ZERO, 1'b1);
    service_mode_i <= 1'b1;
    switch_gas(CH_K, GAS_ZERO, 1'b0);
    service_mode_i <= 1'b0;
    bus(1'b1, REG_CONFIG, 32'h0000_0005);
    switch_gas(CH_M, GAS_ZERO, 1'b1);
    bus(1'b1, REG_CONFIG, 32'h0000_0105);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("status_gas", rd, GAS_ZERO);
    poll({CH_D, CH_A}, 1'b0, 1'b0, 1'b1);
    stall <= 1'b1;
    range_dual_i <= 1'b1;
    {ozonator_off_i, pmt_off_i, local_maint_i, gas_unit_i} <= 4'hE;
    {err_status_i, meas_valid_i, meas_mant_neg_i} <= 24'hC37FC1;
    meas_mant_bcd_i[6] <= 16'h1175;
    meas_exp_bcd_i[7] <= 8'h23;
    poll({CH_D, CH_A, CH_SP, CH_SP, 8'h35}, 1'b1, 1'b0, 1'b1);
    poll({CH_D, CH_A, CH_ZERO, CH_ZERO, 8'h35}, 1'b0, 1'b0, 1'b1);
    poll({CH_D, CH_A}, 1'b1, 1'b1, 1'b0);
    poll({CH_D, CH_A, CH_SP}, 1'b0, 1'b0, 1'b0);
    poll({CH_D, CH_A, CH_ZERO, CH_ZERO, 8'h36}, 1'b0, 1'b0, 1'b0);
    poll({CH_D, CH_STX, CH_D, CH_A}, 1'b0, 1'b0, 1'b1);
    bus(1'b0, REG_POLLS, 32'h0);
    chk("poll_count", rd, 32'h4);
    complete_run();
  end
endmodule
